// ==== inc/wdu_consts.svh ====
`ifndef WDU_CONSTS_SVH
`define WDU_CONSTS_SVH

// Register byte offsets on the AXI4-Lite port.
`define WDU_OFS_CTRL        8'h00
`define WDU_OFS_MODE        8'h04
`define WDU_OFS_DELTA       8'h08
`define WDU_OFS_PROT        8'h0c
`define WDU_OFS_STATUS      8'h10

// Control register fields.
`define WDU_CTRL_RELOAD     0

// Mode register fields.
`define WDU_MODE_RLD_LSB    0
`define WDU_MODE_RLD_MSB    11
`define WDU_MODE_PSC_LSB    12
`define WDU_MODE_PSC_MSB    14
`define WDU_MODE_EN         16
`define WDU_MODE_DBGFRZ     17
`define WDU_MODE_SRC        18

// Status register fields.
`define WDU_STAT_UF         16
`define WDU_STAT_WIN        17
`define WDU_STAT_LOCK       18

// Protection keys: the unlock key clears the lock, any other value sets it.
`define WDU_KEY_UNLOCK      32'h000035ca

// Reset values.
`define WDU_RST_RELOAD      12'hfff
`define WDU_RST_DELTA       12'hfff
`define WDU_RST_PSC         3'h7

// Length of the system reset pulse in sys_clk cycles.
`define WDU_RST_PULSE_CYC   4'h4

// AXI response codes.
`define WDU_RESP_OKAY       2'h0
`define WDU_RESP_SLVERR     2'h2

`endif

// ==== inc/wdu_pkg.sv ====
package wdu_pkg;

  // Watchdog sequencing states.
  typedef enum logic [1:0] {
    WDU_IDLE = 2'b00,
    WDU_RUN  = 2'b01,
    WDU_FIRE = 2'b10
  } wdu_state_t;

  // AXI response code.
  typedef logic [1:0] wdu_resp_t;

  // Counter word.
  typedef logic [11:0] wdu_count_t;

endpackage : wdu_pkg

// ==== verilog/wdu_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module wdu_sync #(
  parameter int WIDTH = 2
) (
  // Clock, reset and enable.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage is read only by the second stage.
  always_comb begin
    meta_d = clk_en ? din : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // Two flip-flops per bit.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : wdu_sync

`default_nettype wire

// ==== verilog/wdu_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none

module wdu_prescaler #(
  parameter int SEL_W = 3
) (
  // Clock, reset and enable.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Low-speed ticks in, divided ticks out.
  input  wire logic             tick,
  input  wire logic             restart,
  input  wire logic [SEL_W-1:0] sel,
  output var  logic             pulse
);

  localparam int DIV_W = (1 << SEL_W) - 1;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic             pulse_q;
  logic             pulse_d;
  logic [DIV_W-1:0] last;

  // Divide by two to the power of sel; a restart drops the partial count.
  always_comb begin
    last    = DIV_W'((1 << sel) - 1);
    div_d   = div_q;
    pulse_d = 1'b0;
    if (restart) begin
      div_d = '0;
    end else if (tick) begin
      if (div_q >= last) begin
        div_d   = '0;
        pulse_d = 1'b1;
      end else begin
        div_d = div_q + DIV_W'(1);
      end
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q   <= '0;
      pulse_q <= 1'b0;
    end else if (clk_en) begin
      div_q   <= div_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule : wdu_prescaler

`default_nettype wire

// ==== verilog/wdu_top.sv ====
// Contract
// - Twelve-bit down-counter advanced through a prescaler selected by a three-bit field.
// - Underflow without a reload asserts the system reset.
// - A reload while the count exceeds the programmed delta asserts the system reset.
// - Optional freeze of the counter while the processor is halted in debug.
// - Enableable write protection blocks changes to the configuration.
// - Counter clock selects internal or external low-speed oscillator.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wdu_consts.svh"

module wdu_top (
  // Clock, reset and enable.
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Low-speed oscillator pins and debug halt.
  input  wire logic              low_speed_internal_osc,
  input  wire logic              low_speed_external_osc,
  input  wire logic              dbg_halt,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // AXI4-Lite write response.
  output var  wdu_pkg::wdu_resp_t s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  wdu_pkg::wdu_resp_t s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // System reset request.
  output var  logic              wd_sys_reset
);

  import wdu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [1:0]  ls_sync;
  logic        ls_sel;
  logic        ls_tick;
  logic        psc_pulse;
  logic        psc_restart;
  logic        run;

  logic        aw_held_q, aw_held_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  wdu_resp_t   bresp_q, bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  wdu_resp_t   rresp_q, rresp_d;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] mode_word;
  logic [31:0] mode_new;
  logic [31:0] delta_new;

  wdu_count_t  reload_q, reload_d;
  logic [2:0]  psc_q, psc_d;
  logic        en_q, en_d;
  logic        frz_q, frz_d;
  logic        src_q, src_d;
  wdu_count_t  delta_q, delta_d;
  logic        lock_q, lock_d;
  logic        reload_req;
  logic        uf_clr;
  logic        win_clr;

  wdu_state_t  state_q, state_d;
  wdu_count_t  cnt_q, cnt_d;
  logic        uf_q, uf_d;
  logic        win_q, win_d;
  logic [3:0]  rst_cnt_q, rst_cnt_d;
  logic        wd_rst_q, wd_rst_d;
  logic        ls_prev_q, ls_prev_d;

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Low-speed clock capture and prescaler.

  // Oscillator pins are asynchronous, so both pass two flip-flops first.
  wdu_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .din     ({low_speed_external_osc, low_speed_internal_osc}),
    .dout    (ls_sync)
  );

  // Source select and rising-edge detect; switching source may cost one tick.
  assign ls_sel    = src_q ? ls_sync[1] : ls_sync[0];
  assign ls_tick   = ls_sel & ~ls_prev_q & run;
  assign ls_prev_d = ls_sel;

  // Counting stops while disabled, firing or frozen by a debug halt.
  assign run = (state_q == WDU_RUN) & ~(frz_q & dbg_halt);

  wdu_prescaler #(
    .SEL_W (3)
  ) u_psc (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .tick    (ls_tick),
    .restart (psc_restart),
    .sel     (psc_q),
    .pulse   (psc_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  assign wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_hit    = (aw_addr_q == `WDU_OFS_CTRL) | (aw_addr_q == `WDU_OFS_MODE) |
                     (aw_addr_q == `WDU_OFS_DELTA) | (aw_addr_q == `WDU_OFS_PROT) |
                     (aw_addr_q == `WDU_OFS_STATUS);
  assign rd_hit    = (s_axi_araddr == `WDU_OFS_CTRL) | (s_axi_araddr == `WDU_OFS_MODE) |
                     (s_axi_araddr == `WDU_OFS_DELTA) | (s_axi_araddr == `WDU_OFS_PROT) |
                     (s_axi_araddr == `WDU_OFS_STATUS);

  assign mode_word = {13'h0000, src_q, frz_q, en_q, 1'b0, psc_q, reload_q};

  // Address and data are held independently; the response follows both.
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid & awready_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid & wready_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? `WDU_RESP_OKAY : `WDU_RESP_SLVERR;
    end else if (bvalid_q & s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = ~aw_held_d & ~bvalid_d;
    wready_d  = ~w_held_d & ~bvalid_d;
  end

  // Read answers one cycle after the address is taken.
  always_comb begin
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid & arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = rd_hit ? `WDU_RESP_OKAY : `WDU_RESP_SLVERR;
      case (s_axi_araddr) // Exact match only, so an unaligned or unmapped address reads zero.
        `WDU_OFS_MODE:   rdata_d = mode_word;
        `WDU_OFS_DELTA:  rdata_d = {20'h00000, delta_q};
        `WDU_OFS_PROT:   rdata_d = {31'h00000000, lock_q};
        `WDU_OFS_STATUS: rdata_d = {13'h0000, lock_q, win_q, uf_q, 4'h0, cnt_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `WDU_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `WDU_RESP_OKAY;
    end else if (clk_en) begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  assign mode_new   = merge_bytes(mode_word, w_data_q, w_strb_q);
  assign delta_new  = merge_bytes({20'h00000, delta_q}, w_data_q, w_strb_q);
  assign reload_req = wr_fire & (aw_addr_q == `WDU_OFS_CTRL) & w_strb_q[0] &
                      w_data_q[`WDU_CTRL_RELOAD];
  assign uf_clr     = wr_fire & (aw_addr_q == `WDU_OFS_STATUS) & w_strb_q[2] &
                      w_data_q[`WDU_STAT_UF];
  assign win_clr    = wr_fire & (aw_addr_q == `WDU_OFS_STATUS) & w_strb_q[2] &
                      w_data_q[`WDU_STAT_WIN];

  // Mode and delta writes are dropped silently while the lock is set.
  always_comb begin
    reload_d = reload_q;
    psc_d    = psc_q;
    en_d     = en_q;
    frz_d    = frz_q;
    src_d    = src_q;
    delta_d  = delta_q;
    lock_d   = lock_q;
    if (wr_fire & ~lock_q & (aw_addr_q == `WDU_OFS_MODE)) begin
      reload_d = mode_new[`WDU_MODE_RLD_MSB:`WDU_MODE_RLD_LSB];
      psc_d    = mode_new[`WDU_MODE_PSC_MSB:`WDU_MODE_PSC_LSB];
      en_d     = mode_new[`WDU_MODE_EN];
      frz_d    = mode_new[`WDU_MODE_DBGFRZ];
      src_d    = mode_new[`WDU_MODE_SRC];
    end
    if (wr_fire & ~lock_q & (aw_addr_q == `WDU_OFS_DELTA)) begin
      delta_d = delta_new[11:0];
    end
    // A full-word key write is needed; anything else arms the lock.
    if (wr_fire & (aw_addr_q == `WDU_OFS_PROT)) begin
      lock_d = ~((w_strb_q == 4'hf) & (w_data_q == `WDU_KEY_UNLOCK));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reload_q <= `WDU_RST_RELOAD;
      psc_q    <= `WDU_RST_PSC;
      en_q     <= 1'b0;
      frz_q    <= 1'b0;
      src_q    <= 1'b0;
      delta_q  <= `WDU_RST_DELTA;
      lock_q   <= 1'b0;
    end else if (clk_en) begin
      reload_q <= reload_d;
      psc_q    <= psc_d;
      en_q     <= en_d;
      frz_q    <= frz_d;
      src_q    <= src_d;
      delta_q  <= delta_d;
      lock_q   <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and reset sequencer.

  // Software is expected to reload only inside the window; early ones fire.
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    rst_cnt_d   = rst_cnt_q;
    wd_rst_d    = 1'b0;
    psc_restart = 1'b0;
    uf_d        = uf_q & ~uf_clr;
    win_d       = win_q & ~win_clr;
    case (state_q)
      WDU_IDLE: begin
        cnt_d       = reload_q;
        psc_restart = 1'b1;
        if (en_q) begin
          state_d = WDU_RUN;
        end
      end
      WDU_RUN: begin
        if (~en_q) begin
          state_d = WDU_IDLE;
        end else if (reload_req) begin
          if (cnt_q > delta_q) begin
            win_d     = 1'b1;
            state_d   = WDU_FIRE;
            rst_cnt_d = `WDU_RST_PULSE_CYC;
          end else begin
            cnt_d       = reload_q;
            psc_restart = 1'b1;
          end
        end else if (psc_pulse & run) begin
          if (cnt_q == 12'h000) begin
            uf_d      = 1'b1;
            state_d   = WDU_FIRE;
            rst_cnt_d = `WDU_RST_PULSE_CYC;
          end else begin
            cnt_d = cnt_q - 12'h001;
          end
        end
      end
      WDU_FIRE: begin
        wd_rst_d    = 1'b1;
        rst_cnt_d   = rst_cnt_q - 4'h1;
        psc_restart = 1'b1;
        cnt_d       = reload_q;
        if (rst_cnt_q == 4'h1) begin
          state_d = WDU_IDLE;
        end
      end
      default: begin
        state_d = WDU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q   <= WDU_IDLE;
      cnt_q     <= `WDU_RST_RELOAD;
      uf_q      <= 1'b0;
      win_q     <= 1'b0;
      rst_cnt_q <= 4'h0;
      wd_rst_q  <= 1'b0;
      ls_prev_q <= 1'b0;
    end else if (clk_en) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      uf_q      <= uf_d;
      win_q     <= win_d;
      rst_cnt_q <= rst_cnt_d;
      wd_rst_q  <= wd_rst_d;
      ls_prev_q <= ls_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wd_sys_reset  = wd_rst_q;

endmodule : wdu_top

`default_nettype wire

// ==== verif/wdu_chk_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "wdu_consts.svh"

module wdu_chk (
  // Clock and reset.
  input wire logic               sys_clk,
  input wire logic               reset,
  // Write channels.
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  // Read channels.
  input wire logic [7:0]         s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire wdu_pkg::wdu_resp_t s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // System reset request.
  input wire logic               wd_sys_reset
);
  import wdu_pkg::*;

  // One clock domain, so clock and disable are given once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // A system reset request is a pulse of exactly four cycles.
  property p_rst_pulse;
    $rose(wd_sys_reset) |-> wd_sys_reset [*4] ##1 !wd_sys_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse length wrong");

  // Both channels are held one cycle, then the response rises; it is seen two edges after the take.
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");

  // No new write is taken while a response is pending.
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during response");

  // A taken response frees the write channels.
  property p_b_free;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_free: assert property (p_b_free) else $error("write channel not freed");

  // Read data follows one cycle after the address.
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");

  // Read data stands until it is taken.
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  // A taken read frees the address channel.
  property p_r_free;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_free: assert property (p_r_free) else $error("read channel not freed");

  // Addresses above the map answer with an error and zero data.
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > `WDU_OFS_STATUS)
      |=> s_axi_rresp == `WDU_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  // Mapped aligned addresses answer OKAY.
  property p_mapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr <= `WDU_OFS_STATUS) && (s_axi_araddr[1:0] == 2'h0)
      |=> s_axi_rresp == `WDU_RESP_OKAY;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read refused");
endmodule : wdu_chk

bind wdu_top wdu_chk wdu_chk_i (.sys_clk(sys_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .wd_sys_reset(wd_sys_reset));
`default_nettype wire

// ==== verif/wdu_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "wdu_consts.svh"

module wdu_tb_top;
  import wdu_pkg::*;

  // Design inputs, all set at time zero.
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic        low_speed_internal_osc = 1'b0;
  logic        low_speed_external_osc = 1'b0;
  logic        dbg_halt = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  // Design outputs.
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wd_sys_reset;
  wdu_resp_t   s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Bench state and tables.
  int          fails = 0, compares = 0, cyc = 0, ci = 0, ce = 0, n, e;
  logic [31:0] rd;
  wdu_resp_t   rr;
  logic [31:0] rv [5] = '{32'h0, 32'h7fff, 32'hfff, 32'h0, 32'hfff};
  int          psc [3] = '{0, 2, 1};
  int          per [3] = '{20, 20, 14};

  wdu_top wdu_top_i (.*);

  ////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;

  // Oscillators of 20 and 14 cycles; unequal so the source select shows in the timing.
  always @(posedge sys_clk) begin
    ci <= (ci == 9) ? 0 : ci + 1;
    ce <= (ce == 6) ? 0 : ce + 1;
    if (ci == 9) low_speed_internal_osc <= ~low_speed_internal_osc;
    if (ce == 6) low_speed_external_osc <= ~low_speed_external_osc;
  end

  // A hang is cut short well above the expected run length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Both write channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input wdu_resp_t er = `WDU_RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  // Read data is left waiting a cycle before rready rises.
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    rdr(a);
    check(nm, rd & m, x);
  endtask : rc

  // Waits at most lim cycles for the reset request to reach level v.
  task automatic wf(input int lim, input logic v);
    n = 0;
    while (wd_sys_reset !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wf

  task automatic stop();
    wr(`WDU_OFS_MODE, 32'h0);
    wf(20, 1'b0);
  endtask : stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rc("reset_value", 8'(i * 4), 32'hffffffff, rv[i]);
    rdr(8'h14);
    check("unmapped_resp", 32'(rr), 32'(`WDU_RESP_SLVERR));
    check("unmapped_data", rd, 32'h0);
    wr(8'h14, 32'h1, 4'hf, `WDU_RESP_SLVERR);
    // Locked configuration ignores writes, unlock restores them.
    wr(`WDU_OFS_PROT, 32'h0);
    rc("lock", `WDU_OFS_PROT, 32'h1, 32'h1);
    wr(`WDU_OFS_DELTA, 32'h123);
    rc("delta_locked", `WDU_OFS_DELTA, 32'hffffffff, 32'hfff);
    wr(`WDU_OFS_MODE, 32'h10003);
    wf(200, 1'b1);
    check("mode_locked", 32'(wd_sys_reset), 32'h0);
    rc("status_lock", `WDU_OFS_STATUS, 32'hffffffff, 32'h40fff);
    wr(`WDU_OFS_PROT, `WDU_KEY_UNLOCK);
    wr(`WDU_OFS_DELTA, 32'h123, 4'h1);
    rc("delta_lane", `WDU_OFS_DELTA, 32'hffffffff, 32'hf23);
    // Underflow period for prescaler settings 0, 2 and 1 and both clock sources, reload value 3.
    for (int i = 0; i < 3; i++) begin
      stop();
      wr(`WDU_OFS_MODE, {13'h0, i == 2, 3'b010, 3'(psc[i]), 12'h003});
      wf(2000, 1'b1);
      wf(10, 1'b0);
      wf(3000, 1'b1);
      e = 4 * (1 << psc[i]) * per[i];
      check("fire_gap", 32'(n >= e - per[i] - 8 && n <= e + 12), 32'h1);
    end
    rc("underflow_flag", `WDU_OFS_STATUS, 32'h10000, 32'h10000);
    // Freeze holds the count only while the processor is halted.
    stop();
    dbg_halt <= 1'b1;
    wr(`WDU_OFS_MODE, 32'h30003);
    wf(300, 1'b1);
    check("frozen", 32'(wd_sys_reset), 32'h0);
    dbg_halt <= 1'b0;
    wf(300, 1'b1);
    check("thawed", 32'(wd_sys_reset), 32'h1);
    wf(10, 1'b0);
    wr(`WDU_OFS_MODE, 32'h10003);
    dbg_halt <= 1'b1;
    wf(300, 1'b1);
    check("no_freeze", 32'(wd_sys_reset), 32'h1);
    dbg_halt <= 1'b0;
    // A reload above delta fires at once and sets the window flag.
    stop();
    wr(`WDU_OFS_DELTA, 32'h100);
    wr(`WDU_OFS_MODE, 32'h17fff);
    wr(`WDU_OFS_CTRL, 32'h1, 4'h1);
    wf(10, 1'b1);
    check("early_fire", 32'(wd_sys_reset), 32'h1);
    wf(10, 1'b0);
    rc("window_flag", `WDU_OFS_STATUS, 32'h20000, 32'h20000);
    wr(`WDU_OFS_STATUS, 32'h20000, 4'h4);
    rc("window_clear", `WDU_OFS_STATUS, 32'h20000, 32'h0);
    // A reload with the count equal to delta is still inside the window and restores the reload value.
    wr(`WDU_OFS_DELTA, 32'h00e);
    stop();
    wr(`WDU_OFS_MODE, 32'h13010);
    repeat (400) @(posedge sys_clk);
    rc("count_down", `WDU_OFS_STATUS, 32'hfff, 32'h00e);
    wr(`WDU_OFS_CTRL, 32'h1, 4'h1);
    wf(8, 1'b1);
    check("good_reload", 32'(wd_sys_reset), 32'h0);
    rc("reloaded", `WDU_OFS_STATUS, 32'hfff, 32'h010);
    // A low clock enable freezes the count over more than one prescaled tick.
    clk_en <= 1'b0;
    repeat (300) @(posedge sys_clk);
    clk_en <= 1'b1;
    rc("clk_en_hold", `WDU_OFS_STATUS, 32'hfff, 32'h010);
    test_done();
  end
endmodule : wdu_tb_top
`default_nettype wire
